// *** dv/dbg_host_model.sv ***
// Debug host model that programs the sequencer configuration
`timescale 1ns/100ps
`default_nettype none

module dbg_host_model
   import seq_break_pkg::*;
(
   input  wire logic    clk_sys,
   output var cpu_seq_t cpu_seq,
   output logic         cpu_free_order_mode,
   output var sb_seq_t  sb_seq,
   output logic         sysbus_free_order_mode,
   output logic [43:0]  ch_prereq,
   output logic [21:0]  ch_flag_act
);
   initial begin
      cpu_seq = CPU_SEQ_OFF;
      sb_seq = SB_SEQ_OFF;
      {cpu_free_order_mode, sysbus_free_order_mode} = 2'h0;
      {ch_prereq, ch_flag_act} = '0;
   end

   // Conditions first, sequence enable one cycle later
   task automatic setup(input cpu_seq_t cs, input sb_seq_t ss,
      input logic cf, input logic sf, input logic [43:0] pr,
      input logic [21:0] fa);
      @(negedge clk_sys);
      cpu_seq = CPU_SEQ_OFF;
      sb_seq = SB_SEQ_OFF;
      {cpu_free_order_mode, sysbus_free_order_mode} = 2'h0;
      {ch_prereq, ch_flag_act} = {pr, fa};
      @(negedge clk_sys);
      cpu_seq = cs;
      sb_seq = ss;
      {cpu_free_order_mode, sysbus_free_order_mode} = {cf, sf};
   endtask
endmodule // dbg_host_model

`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the sequential break and trace unit
`timescale 1ns/100ps
`default_nettype none

module tb_top
   import seq_break_pkg::*;
;
   // ******
   // Signals
   // ******
   logic        clk_sys, nrst, halt_req, seq_match_flag;
   logic [10:0] ch_match;
   cpu_seq_t    cpu_seq;
   sb_seq_t     sb_seq;
   logic        cpu_free_order_mode, sysbus_free_order_mode;
   logic [43:0] ch_prereq;
   logic [21:0] ch_flag_act;
   logic        branch_trace_channel, br_valid, range_trace_en, acc_write;
   logic        range_asid_en, range_cyc_en, acc_valid, sw_trace_en, sw_valid;
   logic [31:0] br_src, br_dst, range_lo, range_hi, acc_addr, acc_data;
   logic [31:0] sw_pc, sw_value;
   logic [3:0]  br_type, trace_rd_count;
   logic [1:0]  br_master, range_cyc, acc_cyc;
   logic [7:0]  range_asid, acc_asid;
   rw_sel_t     range_rw_sel;
   trace_sel_t  trace_rd_sel;
   logic [2:0]  trace_rd_idx;
   logic [74:0] trace_rd_data;
   logic [74:0] mdl[3][$];
   int          n_fail = 0, n_checks = 0, cyc = 0;
   int          exp_q[$];
   int          pa[4] = '{1, 3, 5, 10};
   int          ord[8] = '{10, 9, 5, 4, 3, 2, 1, 0};
   int          fc[12] = '{1, 3, 0, 2, 3, 0, 3, 0, 1, 8, 7, 8};

   seq_break_unit i_dut (
      .clk_sys, .nrst, .ch_match, .cpu_seq, .cpu_free_order_mode, .sb_seq,
      .sysbus_free_order_mode, .ch_prereq, .ch_flag_act,
      .branch_trace_channel, .br_valid, .br_src, .br_dst, .br_type,
      .br_master, .range_trace_en, .range_lo, .range_hi, .range_rw_sel,
      .range_asid_en, .range_asid, .range_cyc_en, .range_cyc, .acc_valid,
      .acc_addr, .acc_data, .acc_write, .acc_asid, .acc_cyc, .sw_trace_en,
      .sw_valid, .sw_pc, .sw_value, .trace_rd_sel, .trace_rd_idx,
      .halt_req, .seq_match_flag, .trace_rd_data, .trace_rd_count
   );

   dbg_host_model i_host (
      .clk_sys, .cpu_seq, .cpu_free_order_mode, .sb_seq,
      .sysbus_free_order_mode, .ch_prereq, .ch_flag_act
   );

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) cyc <= cyc + 1;

   // ******
   // Helpers
   // ******
   task automatic chk(input logic [74:0] seen, input logic [74:0] want);
      n_checks++;
      if (seen !== want) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, seen, want);
      end
   endtask

   always @(negedge clk_sys) begin
      if (halt_req !== 1'b0) begin
         if (exp_q.size() == 0) chk(75'h1, 75'h0);
         else chk(75'(cyc), 75'(exp_q.pop_front()));
      end
   end

   task automatic hit(input int c, input bit fin);
      @(negedge clk_sys);
      ch_match = 11'(1 << c);
      if (fin) exp_q.push_back(cyc + 1);
      @(negedge clk_sys);
      ch_match = '0;
   endtask

   task automatic reset_dut;
      @(negedge clk_sys);
      nrst = 1'b0;
      repeat (2) @(negedge clk_sys);
      nrst = 1'b1;
   endtask

   task automatic put(input int k, input logic [31:0] a, input logic w,
      input logic [9:0] sc, input bit ok);
      logic [74:0] r;
      @(negedge clk_sys);
      {br_src, br_dst, acc_data, sw_pc, sw_value} =
         {$urandom, $urandom, $urandom, $urandom, $urandom};
      {br_type, br_master} = 6'($urandom);
      {acc_addr, acc_write, acc_asid, acc_cyc} = {a, w, sc};
      br_valid = (k == 0);
      acc_valid = (k == 1);
      sw_valid = (k == 2);
      r = (k == 0) ? 75'({br_src, br_dst, br_type, br_master})
        : (k == 1) ? {acc_addr, acc_data, acc_write, acc_asid, acc_cyc}
        : 75'({sw_pc, sw_value});
      if (ok) mdl[k].push_front(r);
      if (mdl[k].size() > 8) void'(mdl[k].pop_back());
   endtask

   task automatic quiet;
      @(negedge clk_sys);
      {br_valid, acc_valid, sw_valid} = 3'h0;
   endtask

   task automatic rd_all(input int k);
      @(negedge clk_sys);
      trace_rd_sel = trace_sel_t'(k);
      for (int i = 0; i < 8; i++) begin
         trace_rd_idx = 3'(i);
         @(negedge clk_sys);
         chk(75'(trace_rd_count), 75'(mdl[k].size()));
         if (i < mdl[k].size()) chk(trace_rd_data, mdl[k][i]);
      end
   endtask

   task automatic test_done;
      if (n_fail == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ******
   // Tests
   // ******
   initial begin
      void'($urandom(32'hEB4A03F7));
      nrst = 1'b0;
      ch_match = '0;
      {branch_trace_channel, br_valid, range_trace_en, acc_write} = 4'h0;
      {range_asid_en, range_cyc_en, acc_valid, sw_trace_en, sw_valid} = 5'h0;
      {br_src, br_dst, range_lo, range_hi, acc_addr, acc_data} = '0;
      {sw_pc, sw_value, br_type, br_master, range_cyc, acc_cyc} = '0;
      {range_asid, acc_asid, trace_rd_idx} = '0;
      range_rw_sel = RW_NONE;
      trace_rd_sel = TSEL_BRANCH;
      repeat (2) @(negedge clk_sys);
      nrst = 1'b1;
      for (int i = 0; i < 4; i++) begin
         i_host.setup(cpu_seq_t'(i + 1), SB_SEQ_OFF, 1'b0, 1'b0, '0, '0);
         hit(pa[i] - 1, 1'b0);
         hit(pa[i], 1'b0);
         hit(pa[i] - 1, 1'b1);
      end
      for (int j = 0; j < 6; j++) begin
         i_host.setup(cpu_seq_t'(5 + j), SB_SEQ_OFF, 1'b0, 1'b0, '0, '0);
         hit(0, 1'b0);
         for (int p = 5 - j; p < 8; p++) hit(ord[p], p == 7);
      end
      for (int s = 1; s < 3; s++) begin
         i_host.setup(CPU_SEQ_OFF, sb_seq_t'(s), 1'b0, 1'b0, '0, '0);
         hit(6 + s, 1'b0);
         hit(9 - s, 1'b0);
         hit(6 + s, 1'b1);
      end
      i_host.setup(CPU_SEQ_P2_1, SB_SEQ_OFF, 1'b0, 1'b0, '0, '0);
      hit(1, 1'b0);
      reset_dut();
      hit(0, 1'b0);
      hit(1, 1'b0);
      hit(0, 1'b1);
      i_host.setup(CPU_SEQ_OFF, SB_SEQ_OFF, 1'b1, 1'b1, 44'h0080030C010,
         22'h21);
      for (int i = 0; i < 12; i++) begin
         hit(fc[i], 1'(12'h940 >> i));
         chk(75'(seq_match_flag), 75'((12'h0A4 >> i) & 12'h1));
      end
      put(0, '0, 1'b0, '0, 1'b0);
      quiet();
      rd_all(0);
      branch_trace_channel = 1'b1;
      sw_trace_en = 1'b1;
      repeat (10) put(0, '0, 1'b0, '0, 1'b1);
      repeat (10) put(2, '0, 1'b0, '0, 1'b1);
      {range_lo, range_hi} = {32'h00001000, 32'h000010FF};
      {range_asid, range_cyc} = 10'h169;
      {range_trace_en, range_asid_en, range_cyc_en} = 3'h7;
      for (int m = 0; m < 4; m++) begin
         quiet();
         range_rw_sel = rw_sel_t'(m);
         put(1, 32'h00001080, 1'b1, 10'h169, m[1]);
         put(1, 32'h00001080, 1'b0, 10'h169, m[0]);
      end
      put(1, 32'h00001000, 1'b0, 10'h169, 1'b1);
      put(1, 32'h000010FF, 1'b1, 10'h169, 1'b1);
      put(1, 32'h00000FFF, 1'b1, 10'h169, 1'b0);
      put(1, 32'h00001100, 1'b0, 10'h169, 1'b0);
      put(1, 32'h00001080, 1'b1, 10'h16D, 1'b0);
      put(1, 32'h00001080, 1'b1, 10'h16A, 1'b0);
      quiet();
      for (int k = 0; k < 3; k++) rd_all(k);
      @(negedge clk_sys);
      trace_rd_sel = trace_sel_t'(3);
      @(negedge clk_sys);
      chk(trace_rd_data, 75'h0);
      chk(75'(trace_rd_count), 75'h0);
      chk(75'(exp_q.size()), 75'h0);
      test_done();
   end

   initial begin
      #200000;
      n_fail++;
      test_done();
   end
endmodule // tb_top

`default_nettype wire

// *** logic/seq_break_defines.svh ***
// Constants for the sequential break and trace unit
`ifndef SEQ_BREAK_DEFINES_SVH
`define SEQ_BREAK_DEFINES_SVH

// ****************************************************************
// Channel layout
// ****************************************************************
`define NUM_CH        11
`define PRQ_W         4
`define ACT_W         2
`define PRQ_NONE      4'h0
`define PRQ_FLAG      4'hC
// Chain position p holds channel bit at [p*4+:4]: 10,9,5,4,3,2,1,0
`define CHAIN_ORDER   32'h0123459A
`define SB_CH8_BIT    4'h7
`define SB_CH9_BIT    4'h8
`define SB_MASK       11'h180

// ****************************************************************
// Sequence bounds {start position, end position}
// ****************************************************************
`define SEQ_P2_1      6'h37
`define SEQ_P4_3      6'h25
`define SEQ_P6_5      6'h13
`define SEQ_P11_10    6'h01
`define SEQ_C3        6'h2F
`define SEQ_C4        6'h27
`define SEQ_C5        6'h1F
`define SEQ_C6        6'h17
`define SEQ_C10       6'h0F
`define SEQ_C11       6'h07

// ****************************************************************
// Trace store
// ****************************************************************
`define TRACE_DEPTH   8
`define ADDR_W        32
`define BR_TYPE_W     4
`define BR_MST_W      2
`define ASID_W        8
`define CYC_W         2
`define BR_REC_W      70
`define ACC_REC_W     75
`define SW_REC_W      64
`define TRACE_RD_W    75

`endif

// *** logic/seq_break_pkg.sv ***
// Types for the sequential break and trace unit
`default_nettype none
package seq_break_pkg;

   typedef enum logic [3:0] {
      CPU_SEQ_OFF   = 4'h0,
      CPU_SEQ_P2_1  = 4'h1,
      CPU_SEQ_P4_3  = 4'h2,
      CPU_SEQ_P6_5  = 4'h3,
      CPU_SEQ_P11_10 = 4'h4,
      CPU_SEQ_C3    = 4'h5,
      CPU_SEQ_C4    = 4'h6,
      CPU_SEQ_C5    = 4'h7,
      CPU_SEQ_C6    = 4'h8,
      CPU_SEQ_C10   = 4'h9,
      CPU_SEQ_C11   = 4'hA
   } cpu_seq_t;

   typedef enum logic [1:0] {
      SB_SEQ_OFF    = 2'h0,
      SB_SEQ_9_8    = 2'h1,
      SB_SEQ_8_9    = 2'h2
   } sb_seq_t;

   typedef enum logic [1:0] {
      FLAG_KEEP     = 2'h0,
      FLAG_SET      = 2'h1,
      FLAG_CLEAR    = 2'h2
   } flag_act_t;

   typedef enum logic [1:0] {
      RW_NONE       = 2'h0,
      RW_READ       = 2'h1,
      RW_WRITE      = 2'h2,
      RW_BOTH       = 2'h3
   } rw_sel_t;

   typedef enum logic [1:0] {
      TSEL_BRANCH   = 2'h0,
      TSEL_RANGE    = 2'h1,
      TSEL_SOFT     = 2'h2
   } trace_sel_t;

endpackage

`default_nettype wire

// *** logic/seq_break_unit.sv ***
// Sequential break sequencer with internal trace store
`timescale 1ns/100ps
`default_nettype none
`include "seq_break_defines.svh"

module seq_break_unit
   import seq_break_pkg::*;
(
   input  wire logic                          clk_sys,
   input  wire logic                          nrst,
   input  wire logic [`NUM_CH-1:0]            ch_match,
   input  wire cpu_seq_t                      cpu_seq,
   input  wire logic                          cpu_free_order_mode,
   input  wire sb_seq_t                       sb_seq,
   input  wire logic                          sysbus_free_order_mode,
   input  wire logic [`NUM_CH*`PRQ_W-1:0]     ch_prereq,
   input  wire logic [`NUM_CH*`ACT_W-1:0]     ch_flag_act,
   input  wire logic                          branch_trace_channel,
   input  wire logic                          br_valid,
   input  wire logic [`ADDR_W-1:0]            br_src,
   input  wire logic [`ADDR_W-1:0]            br_dst,
   input  wire logic [`BR_TYPE_W-1:0]         br_type,
   input  wire logic [`BR_MST_W-1:0]          br_master,
   input  wire logic                          range_trace_en,
   input  wire logic [`ADDR_W-1:0]            range_lo,
   input  wire logic [`ADDR_W-1:0]            range_hi,
   input  wire rw_sel_t                       range_rw_sel,
   input  wire logic                          range_asid_en,
   input  wire logic [`ASID_W-1:0]            range_asid,
   input  wire logic                          range_cyc_en,
   input  wire logic [`CYC_W-1:0]             range_cyc,
   input  wire logic                          acc_valid,
   input  wire logic [`ADDR_W-1:0]            acc_addr,
   input  wire logic [`ADDR_W-1:0]            acc_data,
   input  wire logic                          acc_write,
   input  wire logic [`ASID_W-1:0]            acc_asid,
   input  wire logic [`CYC_W-1:0]             acc_cyc,
   input  wire logic                          sw_trace_en,
   input  wire logic                          sw_valid,
   input  wire logic [`ADDR_W-1:0]            sw_pc,
   input  wire logic [`ADDR_W-1:0]            sw_value,
   input  wire trace_sel_t                    trace_rd_sel,
   input  wire logic [2:0]                    trace_rd_idx,
   output logic                               halt_req,
   output logic                               seq_match_flag,
   output logic [`TRACE_RD_W-1:0]             trace_rd_data,
   output logic [3:0]                         trace_rd_count
);

   // ****************************************************************
   // Fixed CPU sequences
   // ****************************************************************
   localparam logic [31:0] CHAIN = `CHAIN_ORDER;

   function automatic logic [5:0] seq_bounds(input cpu_seq_t m);
      unique case (m)
         CPU_SEQ_P2_1:   seq_bounds = `SEQ_P2_1;
         CPU_SEQ_P4_3:   seq_bounds = `SEQ_P4_3;
         CPU_SEQ_P6_5:   seq_bounds = `SEQ_P6_5;
         CPU_SEQ_P11_10: seq_bounds = `SEQ_P11_10;
         CPU_SEQ_C3:     seq_bounds = `SEQ_C3;
         CPU_SEQ_C4:     seq_bounds = `SEQ_C4;
         CPU_SEQ_C5:     seq_bounds = `SEQ_C5;
         CPU_SEQ_C6:     seq_bounds = `SEQ_C6;
         CPU_SEQ_C10:    seq_bounds = `SEQ_C10;
         CPU_SEQ_C11:    seq_bounds = `SEQ_C11;
         default:        seq_bounds = 6'h00;
      endcase
   endfunction

   logic [2:0]  seq_step;
   cpu_seq_t    last_cpu_seq;
   wire         halt_now;
   wire  [5:0]  bounds    = seq_bounds(cpu_seq);
   wire  [2:0]  seq_start = bounds[5:3];
   wire  [2:0]  seq_end   = bounds[2:0];
   wire  [2:0]  seq_pos   = 3'(seq_start + seq_step);
   wire  [3:0]  pos_ch    = CHAIN[{seq_pos, 2'b00} +: 4];
   wire         cpu_on    = (cpu_seq != CPU_SEQ_OFF) && !cpu_free_order_mode;
   wire         pos_hit   = cpu_on && ch_match[pos_ch];
   wire         seq_last  = (seq_pos == seq_end) && (cpu_seq == last_cpu_seq);
   wire         cpu_hit   = pos_hit && seq_last;
   wire         cpu_restart = halt_now || (cpu_seq != last_cpu_seq);
   wire  [2:0]  next_seq_step = cpu_restart ? 3'h0 :
                               pos_hit ? 3'(seq_step + 1'b1) : seq_step;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         seq_step     <= 3'h0;
         last_cpu_seq <= CPU_SEQ_OFF;
      end else begin
         seq_step     <= next_seq_step;
         last_cpu_seq <= cpu_seq;
      end
   end

   // ****************************************************************
   // System-bus sequences
   // ****************************************************************
   logic        sb_first;
   sb_seq_t     last_sb_seq;
   wire         sb_on     = (sb_seq != SB_SEQ_OFF) && !sysbus_free_order_mode;
   wire  [3:0]  sb_a_bit  = (sb_seq == SB_SEQ_9_8) ? `SB_CH9_BIT : `SB_CH8_BIT;
   wire  [3:0]  sb_b_bit  = (sb_seq == SB_SEQ_9_8) ? `SB_CH8_BIT : `SB_CH9_BIT;
   wire         sb_hit    = sb_on && sb_first && ch_match[sb_b_bit] &&
                            (sb_seq == last_sb_seq);
   wire         next_sb_first = (halt_now || sb_seq != last_sb_seq) ? 1'b0 :
                               (sb_first || (sb_on && ch_match[sb_a_bit]));

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sb_first    <= 1'b0;
         last_sb_seq <= SB_SEQ_OFF;
      end else begin
         sb_first    <= next_sb_first;
         last_sb_seq <= sb_seq;
      end
   end

   // ****************************************************************
   // Free-order channels
   // ****************************************************************
   logic [`NUM_CH-1:0] seen;
   logic [`NUM_CH-1:0] ext_on;
   logic [`NUM_CH-1:0] qual;
   logic [`NUM_CH-1:0] flag_set;
   logic [`NUM_CH-1:0] flag_clr;
   logic [`NUM_CH-1:0] prq_hot [`NUM_CH];
   logic [`NUM_CH-1:0] is_prereq;
   wire  [`NUM_CH:0]   pre_vec = {seq_match_flag, seen};
   localparam logic [`NUM_CH-1:0] SB_MASK = `SB_MASK;

   for (genvar g = 0; g < `NUM_CH; g++) begin : g_ch
      wire [`PRQ_W-1:0] sel = ch_prereq[g*`PRQ_W +: `PRQ_W];
      wire flag_act_t   act = flag_act_t'(ch_flag_act[g*`ACT_W +: `ACT_W]);
      wire [`PRQ_W-1:0] sel_m1 = `PRQ_W'(sel - 1'b1);
      wire pre_ok = (sel == `PRQ_NONE) ||
                    (sel <= `PRQ_FLAG && pre_vec[sel_m1]);
      assign ext_on[g]   = SB_MASK[g] ? sysbus_free_order_mode
                                      : cpu_free_order_mode;
      assign qual[g]     = ext_on[g] && ch_match[g] && pre_ok;
      assign flag_set[g] = qual[g] && (act == FLAG_SET);
      assign flag_clr[g] = qual[g] && (act == FLAG_CLEAR);
      assign prq_hot[g]  = (ext_on[g] && sel != `PRQ_NONE &&
                            sel < `PRQ_FLAG) ?
                           `NUM_CH'(1 << sel_m1) : '0;

      prereq_gate_a: assert property (@(posedge clk_sys)
         disable iff (!nrst)
         (sel != `PRQ_NONE && sel < `PRQ_FLAG && !pre_vec[sel_m1])
         |-> !qual[g])
         else $error("match qualified without its prerequisite");

      flag_gate_a: assert property (@(posedge clk_sys)
         disable iff (!nrst)
         (sel == `PRQ_FLAG && !seq_match_flag) |-> !qual[g])
         else $error("match qualified while match flag clear");
   end

   always_comb begin
      is_prereq = '0;
      for (int j = 0; j < `NUM_CH; j++) begin
         is_prereq = is_prereq | prq_hot[j];
      end
   end

   wire ext_break = |(qual & ~is_prereq);
   assign halt_now = cpu_hit || sb_hit || ext_break;
   wire next_flag = halt_now ? 1'b0 :
                    (|flag_set) ? 1'b1 :
                    (|flag_clr) ? 1'b0 : seq_match_flag;
   wire [`NUM_CH-1:0] next_seen = halt_now ? '0 : ((seen | qual) & ext_on);

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         seen           <= '0;
         seq_match_flag <= 1'b0;
         halt_req       <= 1'b0;
      end else begin
         seen           <= next_seen;
         seq_match_flag <= next_flag;
         halt_req       <= halt_now;
      end
   end

   // ****************************************************************
   // Internal trace store
   // ****************************************************************
   wire in_win  = (acc_addr >= range_lo) && (acc_addr <= range_hi);
   wire rw_ok   = (range_rw_sel == RW_BOTH) ||
                  (range_rw_sel == RW_READ  && !acc_write) ||
                  (range_rw_sel == RW_WRITE &&  acc_write);
   wire asid_ok = !range_asid_en || (acc_asid == range_asid);
   wire cyc_ok  = !range_cyc_en  || (acc_cyc  == range_cyc);
   wire range_wr = range_trace_en && acc_valid && in_win &&
                   rw_ok && asid_ok && cyc_ok;
   wire br_wr   = branch_trace_channel && br_valid;
   wire sw_wr   = sw_trace_en && sw_valid;
   wire [`BR_REC_W-1:0]  br_rec  = {br_src, br_dst, br_type, br_master};
   wire [`ACC_REC_W-1:0] acc_rec = {acc_addr, acc_data, acc_write,
                                    acc_asid, acc_cyc};
   wire [`SW_REC_W-1:0]  sw_rec  = {sw_pc, sw_value};
   wire [`BR_REC_W-1:0]  br_rd;
   wire [`ACC_REC_W-1:0] acc_rd;
   wire [`SW_REC_W-1:0]  sw_rd;
   wire [3:0]            br_cnt;
   wire [3:0]            acc_cnt;
   wire [3:0]            sw_cnt;

   trace_ring #(.W(`BR_REC_W), .DEPTH(`TRACE_DEPTH)) u_br_ring (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .wr_valid (br_wr),
      .wr_data  (br_rec),
      .rd_idx   (trace_rd_idx),
      .rd_data  (br_rd),
      .count    (br_cnt)
   );

   trace_ring #(.W(`ACC_REC_W), .DEPTH(`TRACE_DEPTH)) u_acc_ring (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .wr_valid (range_wr),
      .wr_data  (acc_rec),
      .rd_idx   (trace_rd_idx),
      .rd_data  (acc_rd),
      .count    (acc_cnt)
   );

   trace_ring #(.W(`SW_REC_W), .DEPTH(`TRACE_DEPTH)) u_sw_ring (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .wr_valid (sw_wr),
      .wr_data  (sw_rec),
      .rd_idx   (trace_rd_idx),
      .rd_data  (sw_rd),
      .count    (sw_cnt)
   );

   wire [`TRACE_RD_W-1:0] next_rd_data =
      (trace_rd_sel == TSEL_BRANCH) ? `TRACE_RD_W'(br_rd) :
      (trace_rd_sel == TSEL_RANGE)  ? acc_rd :
      (trace_rd_sel == TSEL_SOFT)   ? `TRACE_RD_W'(sw_rd) : '0;
   wire [3:0] next_rd_count =
      (trace_rd_sel == TSEL_BRANCH) ? br_cnt :
      (trace_rd_sel == TSEL_RANGE)  ? acc_cnt :
      (trace_rd_sel == TSEL_SOFT)   ? sw_cnt : 4'h0;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         trace_rd_data  <= '0;
         trace_rd_count <= 4'h0;
      end else begin
         trace_rd_data  <= next_rd_data;
         trace_rd_count <= next_rd_count;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   pair_order_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (cpu_seq == CPU_SEQ_P2_1 && !cpu_free_order_mode && seq_step == 3'h1
       && ch_match[0] && last_cpu_seq == cpu_seq) |=> halt_req)
      else $error("pair sequence did not halt on second channel");

   chain_step_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (pos_hit && !seq_last && !halt_now && cpu_seq == last_cpu_seq)
      |=> seq_step == 3'($past(seq_step) + 1'b1))
      else $error("chain did not advance on its channel");

   sb_order_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (sb_on && !sb_first && cpu_seq == CPU_SEQ_OFF && !cpu_free_order_mode)
      |=> !halt_req)
      else $error("system bus halt without first channel");

   prereq_quiet_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      halt_req |-> $past(cpu_hit || sb_hit || |(qual & ~is_prereq)))
      else $error("halt raised by prerequisite channel only");

   flag_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (|flag_set && !halt_now) |=> seq_match_flag)
      else $error("match flag not set by qualified match");

   flag_init_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      halt_req |-> !seq_match_flag && seen == '0)
      else $error("match flag not cleared on halt");

   range_win_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      range_wr |-> acc_addr >= range_lo && acc_addr <= range_hi)
      else $error("range trace outside address window");

   range_rw_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (range_wr && range_rw_sel == RW_READ) |-> !acc_write)
      else $error("write recorded in read-only range trace");

   restart_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      halt_req |-> seq_step == 3'h0 && !sb_first)
      else $error("sequence progress kept after halt");

   store_depth_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      br_cnt <= 4'h8 && acc_cnt <= 4'h8 && sw_cnt <= 4'h8)
      else $error("trace store above eight records");

   chain_full_c: cover property (@(posedge clk_sys) disable iff (!nrst)
      cpu_hit && cpu_seq == CPU_SEQ_C11);

   sb_hit_c: cover property (@(posedge clk_sys) disable iff (!nrst)
      sb_hit ##1 halt_req);

   ext_break_c: cover property (@(posedge clk_sys) disable iff (!nrst)
      ext_break && seq_match_flag);

   ring_wrap_c: cover property (@(posedge clk_sys) disable iff (!nrst)
      br_cnt == 4'h8 && br_wr);

endmodule // seq_break_unit

`default_nettype wire

// *** logic/trace_ring.sv ***
// Ring store keeping the most recent trace records
`timescale 1ns/100ps
`default_nettype none

module trace_ring #(
   parameter int W     = 64,
   parameter int DEPTH = 8
) (
   input  wire logic                       clk_sys,
   input  wire logic                       nrst,
   input  wire logic                       wr_valid,
   input  wire logic [W-1:0]               wr_data,
   input  wire logic [$clog2(DEPTH)-1:0]   rd_idx,
   output logic      [W-1:0]               rd_data,
   output logic      [$clog2(DEPTH):0]     count
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;

   // Index 0 is the newest record
   assign rd_ptr  = AW'(wr_ptr - rd_idx - 1'b1);
   assign rd_data = mem[rd_ptr];

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= '0;
         count  <= '0;
      end else if (wr_valid) begin
         wr_ptr <= AW'(wr_ptr + 1'b1);
         if (count != (AW+1)'(DEPTH)) begin
            count <= (AW+1)'(count + 1'b1);
         end
      end
   end

   // Oldest record is overwritten once full
   always_ff @(posedge clk_sys) begin
      if (wr_valid) begin
         mem[wr_ptr] <= wr_data;
      end
   end

   ring_bound_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      count <= (AW+1)'(DEPTH))
      else $error("trace ring count above depth");

endmodule // trace_ring

`default_nettype wire
